/* File: acs_pkg.sv */
package acs_pkg;
   function automatic int ceil_div(input int num, input int den);
      return (num + den - 1) / den;
   endfunction : ceil_div

   localparam int CLK_PERIOD_NS = 10;
   localparam int CLK_KHZ = 100000;
   localparam int SAR_CLK_KHZ = 4000;
   localparam int POWER_UP_TIME_NS = 1000;
   localparam int ACQUISITION_TIME_NS = 1400;
   localparam int CONVERSION_TIME_NS = 3700;
   localparam int POWER_UP_CYC = ceil_div(POWER_UP_TIME_NS, CLK_PERIOD_NS);
   localparam int ACQ_CYC = ceil_div(ACQUISITION_TIME_NS, CLK_PERIOD_NS);
   // Longest time, so it rounds down
   localparam int CONV_CYC = CONVERSION_TIME_NS / CLK_PERIOD_NS;
   localparam int SAR_DIV = CLK_KHZ / SAR_CLK_KHZ;
   localparam int RESULT_BITS = 10;
   localparam int PAD_BITS = 2;
   localparam int FIFO_DEPTH = 16;

   typedef enum logic [2:0] {
      ST_OFF,
      ST_TRACK,
      ST_SEL_LOW,
      ST_CONVERT,
      ST_STORE
   } acs_state_type;
endpackage : acs_pkg

/* File: acs_fifo_if.sv */
`timescale 1ns/1ps
interface acs_fifo_if #(
   parameter int W = 10
);
   logic push_valid;
   logic push_ready;
   logic [W-1:0] push_data;
   logic pop_valid;
   logic pop_ready;
   logic [W-1:0] pop_data;

   modport user (
      output push_valid, push_data, pop_ready,
      input push_ready, pop_valid, pop_data
   );
   modport fifo (
      input push_valid, push_data, pop_ready,
      output push_ready, pop_valid, pop_data
   );
endinterface : acs_fifo_if

/* File: acs_fifo.sv */
`timescale 1ns/1ps
module acs_fifo #(
   parameter int W = 10,
   parameter int DEPTH = 16
) (
   input wire logic clk_i,
   input wire logic arst_n_i,
   acs_fifo_if.fifo f
);
   // DEPTH must be a power of two so the pointers wrap by themselves
   localparam int AW = $clog2(DEPTH);
   localparam int CW = $clog2(DEPTH + 1);

   logic [W-1:0] mem_ff [DEPTH];
   logic [AW-1:0] wr_ptr_ff;
   logic [AW-1:0] rd_ptr_ff;
   logic [CW-1:0] cnt_ff;
   logic out_valid_ff;
   logic [W-1:0] out_ff;
   logic push;
   logic load;

   assign f.push_ready = (cnt_ff != CW'(DEPTH));
   assign push = f.push_valid && f.push_ready;
   assign load = (cnt_ff != '0) && (!out_valid_ff || f.pop_ready);
   assign f.pop_valid = out_valid_ff;
   assign f.pop_data = out_ff;

   always_ff @(posedge clk_i) begin
      if (push) begin
         mem_ff[wr_ptr_ff] <= f.push_data;
      end
   end

   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         wr_ptr_ff <= '0;
         rd_ptr_ff <= '0;
         cnt_ff <= '0;
      end else begin
         if (push) begin
            wr_ptr_ff <= wr_ptr_ff + AW'(1);
         end
         if (load) begin
            rd_ptr_ff <= rd_ptr_ff + AW'(1);
         end
         cnt_ff <= cnt_ff + CW'(push) - CW'(load);
      end
   end

   // Read data leave the memory through a register
   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         out_valid_ff <= 1'b0;
         out_ff <= '0;
      end else if (load) begin
         out_valid_ff <= 1'b1;
         out_ff <= mem_ff[rd_ptr_ff];
      end else if (f.pop_ready) begin
         out_valid_ff <= 1'b0;
      end
   end
endmodule : acs_fifo

/* File: acs_sequencer.sv */
`timescale 1ns/1ps
// Contract
// RL1 - Strobe rise powers up the sampler and starts tracking the chosen input.
// RL2 - Strobe fall holds the sample and starts the conversion.
// RL3 - Host holds strobe high at least the acquisition time, 1.4 us minimum.
// RL4 - Power-up takes about 1 us, counted inside acquisition.
// RL5 - MSB is on the serial output within 3.7 us of strobe fall.
// RL6 - After conversion the device shuts down by itself.
// RL7 - Single rise from idle selects and tracks channel one.
// RL8 - High, low, high pulse pair (30 ns each) selects channel two.
// RL9 - Host clocks out all 12 positions before the next strobe rise.
// RL10 - Strobe rise before 12 positions were read forces channel two.
// RL11 - Frame is ten result bits MSB first, then two zeros, then release.
// RL12 - Each conversion makes a 10-bit result by successive approximation.
// RL13 - Strobe rise also drives the serial output low.
// RL14 - Output changes on falling serial clock; host samples on rising.
// RL15 - Approximation steps at 4 MHz, independent of the serial clock.
// RL16 - After the last position the serial output goes high impedance.
// RL17 - Host keeps strobe low and still during conversion.
// RL18 - Serial clock rising edges are counted since the end of conversion.
module acs_sequencer #(
   parameter int RB = acs_pkg::RESULT_BITS,
   parameter int DEPTH = acs_pkg::FIFO_DEPTH
) (
   input wire logic clk_i,
   input wire logic arst_n_i,
   input wire logic convert_strobe_i,
   input wire logic sclk_i,
   input wire logic cmp_above_i,
   output logic track_o,
   output logic hold_o,
   output logic chan_two_o,
   output logic power_up_o,
   output logic power_ready_o,
   output logic [acs_pkg::RESULT_BITS-1:0] dac_code_o,
   output logic dout_o,
   output logic dout_oe_o
);
   import acs_pkg::*;

   localparam int FB = RB + PAD_BITS;
   localparam int IW = $clog2(RB);
   localparam int FW = $clog2(FB + 1);
   localparam int DW = $clog2(SAR_DIV);
   localparam int AW = $clog2(ACQ_CYC + 1);
   localparam int PW = $clog2(POWER_UP_CYC + 1);
   localparam int CW = $clog2(CONV_CYC + 2);

   acs_fifo_if #(.W(RB)) fq ();

   acs_fifo #(.W(RB), .DEPTH(DEPTH)) u_fifo (
      .clk_i(clk_i),
      .arst_n_i(arst_n_i),
      .f(fq.fifo)
   );

   logic [2:0] cs_ff;
   logic [2:0] sck_ff;
   logic [1:0] cmp_ff;
   acs_state_type state_ff;
   acs_state_type nxt_state;
   logic chan_two_ff;
   logic [AW-1:0] acq_cnt_ff;
   logic [PW-1:0] pwr_cnt_ff;
   logic [DW-1:0] div_ff;
   logic [IW-1:0] idx_ff;
   logic [RB-1:0] sar_ff;
   logic [FB-1:0] sh_ff;
   logic [FW-1:0] frame_cnt_ff;
   logic dout_ff;
   logic oe_ff;
   logic rise_det;
   logic fall_det;
   logic sck_rise;
   logic sck_fall;
   logic tick;
   logic sar_done;
   logic incomplete;
   logic load;
   logic enter_conv;

   // Pins are asynchronous; bit 0 is read only by bit 1
   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         cs_ff <= '0;
         sck_ff <= '0;
         cmp_ff <= '0;
      end else begin
         cs_ff <= {cs_ff[1:0], convert_strobe_i};
         sck_ff <= {sck_ff[1:0], sclk_i};
         cmp_ff <= {cmp_ff[0], cmp_above_i};
      end
   end

   assign rise_det = cs_ff[1] && !cs_ff[2];
   assign fall_det = !cs_ff[1] && cs_ff[2];
   assign sck_rise = sck_ff[1] && !sck_ff[2];
   assign sck_fall = !sck_ff[1] && sck_ff[2];
   assign tick = (div_ff == DW'(SAR_DIV - 1));
   assign sar_done = (state_ff == ST_CONVERT) && tick && (idx_ff == '0);
   assign incomplete = (frame_cnt_ff != '0) || fq.pop_valid;
   assign enter_conv = (state_ff == ST_TRACK) && (nxt_state == ST_CONVERT);

   // While channel one is selected, a short high pulse before acquisition can have elapsed is a select pulse
   always_comb begin
      nxt_state = state_ff;
      case (state_ff)
         ST_OFF: begin
            if (rise_det) nxt_state = ST_TRACK; // RL1
         end
         ST_TRACK: begin
            if (fall_det) begin
               if (!chan_two_ff && (acq_cnt_ff < AW'(ACQ_CYC))) begin
                  nxt_state = ST_SEL_LOW; // RL8
               end else begin
                  nxt_state = ST_CONVERT; // RL2
               end
            end
         end
         ST_SEL_LOW: begin
            if (rise_det) nxt_state = ST_TRACK; // RL8
         end
         ST_CONVERT: begin
            if (sar_done) nxt_state = ST_STORE;
         end
         // Strobe edges here are ignored, the host must leave it alone
         ST_STORE: begin
            if (fq.push_ready) nxt_state = ST_OFF;
         end
         default: nxt_state = ST_OFF;
      endcase
   end

   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         state_ff <= ST_OFF;
      end else begin
         state_ff <= nxt_state;
      end
   end

   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         chan_two_ff <= 1'b0;
      end else if (rise_det && state_ff == ST_OFF) begin
         chan_two_ff <= incomplete; // RL7 RL10
      end else if (rise_det && state_ff == ST_SEL_LOW) begin
         chan_two_ff <= 1'b1; // RL8
      end
   end

   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         acq_cnt_ff <= '0;
      end else if (rise_det) begin
         acq_cnt_ff <= '0;
      end else if (state_ff == ST_TRACK && acq_cnt_ff != AW'(ACQ_CYC)) begin
         acq_cnt_ff <= acq_cnt_ff + AW'(1);
      end
   end

   // Power-up runs inside acquisition and ends with the conversion
   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         pwr_cnt_ff <= '0;
      end else if (state_ff == ST_OFF || state_ff == ST_STORE || sar_done) begin
         pwr_cnt_ff <= '0; // RL6
      end else if (pwr_cnt_ff != PW'(POWER_UP_CYC)) begin
         pwr_cnt_ff <= pwr_cnt_ff + PW'(1); // RL4
      end
   end

   // Divider restarts at hold so every conversion lasts the same
   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         div_ff <= '0;
         idx_ff <= '0;
         sar_ff <= '0;
      end else if (enter_conv) begin
         div_ff <= '0;
         idx_ff <= IW'(RB - 1);
         sar_ff <= {1'b1, {(RB - 1){1'b0}}}; // RL12
      end else if (state_ff == ST_CONVERT) begin
         div_ff <= tick ? '0 : div_ff + DW'(1); // RL15
         if (tick) begin
            if (!cmp_ff[1]) sar_ff[idx_ff] <= 1'b0; // RL12
            if (idx_ff != '0) begin
               sar_ff[idx_ff - IW'(1)] <= 1'b1;
               idx_ff <= idx_ff - IW'(1);
            end
         end
      end
   end

   assign fq.push_valid = (state_ff == ST_STORE);
   assign fq.push_data = sar_ff;
   assign fq.pop_ready = (frame_cnt_ff == '0) && !rise_det;
   assign load = fq.pop_valid && fq.pop_ready;

   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         sh_ff <= '0;
         frame_cnt_ff <= '0;
         dout_ff <= 1'b0;
         oe_ff <= 1'b0;
      end else if (rise_det) begin
         frame_cnt_ff <= '0;
         dout_ff <= 1'b0; // RL13
         oe_ff <= 1'b1;
      end else if (load) begin
         sh_ff <= {fq.pop_data, {PAD_BITS{1'b0}}}; // RL11
         frame_cnt_ff <= FW'(FB);
         dout_ff <= fq.pop_data[RB-1]; // RL5
         oe_ff <= 1'b1;
      end else if (frame_cnt_ff != '0) begin
         if (sck_rise) begin
            frame_cnt_ff <= frame_cnt_ff - FW'(1); // RL18
            if (frame_cnt_ff == FW'(1)) oe_ff <= 1'b0; // RL16
         end else if (sck_fall) begin
            sh_ff <= {sh_ff[FB-2:0], 1'b0};
            dout_ff <= sh_ff[FB-2]; // RL14
         end
      end
   end

   assign track_o = (state_ff == ST_TRACK);
   assign hold_o = (state_ff == ST_CONVERT);
   assign chan_two_o = chan_two_ff;
   assign power_up_o = (state_ff == ST_TRACK) || (state_ff == ST_SEL_LOW)
                       || (state_ff == ST_CONVERT);
   assign power_ready_o = (pwr_cnt_ff == PW'(POWER_UP_CYC));
   assign dac_code_o = sar_ff;
   assign dout_o = dout_ff;
   assign dout_oe_o = oe_ff;

   // Checking helpers: time from hold to MSB, length of approximation
   localparam int CONV_LIM = CONV_CYC;
   localparam int SAR_MIN = RB * SAR_DIV;
   logic [CW-1:0] conv_cnt_ff;
   logic conv_wait_ff;

   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         conv_cnt_ff <= '0;
         conv_wait_ff <= 1'b0;
      end else if (enter_conv) begin
         conv_cnt_ff <= '0;
         conv_wait_ff <= 1'b1;
      end else if (load || rise_det) begin
         conv_wait_ff <= 1'b0;
      end else if (conv_wait_ff && conv_cnt_ff != CW'(CONV_CYC + 1)) begin
         conv_cnt_ff <= conv_cnt_ff + CW'(1);
      end
   end

   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!arst_n_i);

   chk_rise_tracks: assert property ( // RL1
      (rise_det && state_ff == ST_OFF) |=> track_o && power_up_o)
      else $error("strobe rise did not start tracking");
   chk_rise_low: assert property ( // RL13
      rise_det |=> dout_oe_o && !dout_o && frame_cnt_ff == '0)
      else $error("serial output not driven low on strobe rise");
   chk_fall_holds: assert property ( // RL2
      (state_ff == ST_TRACK && fall_det && acq_cnt_ff == AW'(ACQ_CYC))
      |=> hold_o && !track_o)
      else $error("strobe fall did not hold the sample");
   chk_power_time: assert property ( // RL4
      $rose(power_ready_o) |-> $past(power_up_o, 8)
      && pwr_cnt_ff == PW'(POWER_UP_CYC))
      else $error("power-up interval wrong");
   chk_msb_deadline: assert property ( // RL5
      (load && conv_wait_ff) |-> conv_cnt_ff <= CW'(CONV_LIM))
      else $error("MSB later than conversion time");
   chk_sar_length: assert property ( // RL12
      (sar_done && conv_wait_ff) |-> conv_cnt_ff >= CW'(SAR_MIN - 1))
      else $error("approximation too short");
   chk_auto_shutdown: assert property ( // RL6
      sar_done |=> !power_up_o && !power_ready_o)
      else $error("no shutdown after conversion");
   chk_chan_one: assert property ( // RL7
      (rise_det && state_ff == ST_OFF && !incomplete) |=> !chan_two_o)
      else $error("channel one not selected");
   chk_chan_pair: assert property ( // RL8
      (rise_det && state_ff == ST_SEL_LOW) |=> chan_two_o && track_o)
      else $error("pulse pair did not select channel two");
   chk_chan_forced: assert property ( // RL10
      (rise_det && state_ff == ST_OFF && frame_cnt_ff != '0)
      |=> chan_two_o)
      else $error("unread frame did not force channel two");
   chk_frame_pad: assert property ( // RL11
      (frame_cnt_ff == FW'(PAD_BITS - 1) && oe_ff)
      |-> sh_ff[FB-1:FB-PAD_BITS] == '0)
      else $error("padding bits not zero");
   chk_frame_release: assert property ( // RL16
      (sck_rise && frame_cnt_ff == FW'(1) && !rise_det) |=> !dout_oe_o
      ##1 !dout_oe_o)
      else $error("output not released after last position");
   chk_dout_fall: assert property ( // RL14
      (dout_oe_o && $changed(dout_o) && !$past(rise_det) && !$past(load))
      |-> $past(sck_fall))
      else $error("serial output changed off a falling edge");
   chk_edge_count: assert property ( // RL18
      (sck_rise && frame_cnt_ff != '0 && !rise_det && !load)
      |=> frame_cnt_ff == $past(frame_cnt_ff) - FW'(1))
      else $error("serial clock edge not counted");

   cov_chan_one: cover property (
      rise_det && state_ff == ST_OFF && !incomplete);
   cov_chan_two: cover property (rise_det && state_ff == ST_SEL_LOW);
   cov_forced: cover property (rise_det && state_ff == ST_OFF && incomplete);
   cov_release: cover property ($fell(dout_oe_o));
endmodule : acs_sequencer

/* File: acs_host_model.sv */
`timescale 1ns/1ps
module acs_host_model (
   input wire logic clk_i,
   input wire logic dout_i,
   output logic convert_strobe_o,
   output logic sclk_o
);
   initial begin
      convert_strobe_o = 1'b0;
      sclk_o = 1'b0;
   end

   task automatic wait_clk(input int n);
      repeat (n) @(posedge clk_i);
   endtask : wait_clk

   // Pulses of 5 cycles stay well above the 30 ns minimum
   task automatic start(input bit pair);
      @(posedge clk_i);
      convert_strobe_o <= 1'b1;
      if (pair) begin
         wait_clk(5);
         convert_strobe_o <= 1'b0;
         wait_clk(5);
         convert_strobe_o <= 1'b1;
      end
   endtask : start

   // Strobe then stays low until the next start
   task automatic stop();
      @(posedge clk_i);
      convert_strobe_o <= 1'b0;
   endtask : stop

   // Link clock runs only inside a frame, 16 cycles a period
   task automatic read_bits(input int n, output logic [11:0] word);
      word = 12'h000;
      for (int i = 0; i < n; i++) begin
         @(posedge clk_i);
         sclk_o <= 1'b1;
         word = {word[10:0], dout_i};
         wait_clk(8);
         sclk_o <= 1'b0;
         wait_clk(7);
      end
   endtask : read_bits
endmodule : acs_host_model

/* File: adc_conversion_sequencer_tb_top.sv */
`timescale 1ns/1ps
module adc_conversion_sequencer_tb_top;
   logic clk_i;
   logic arst_n_i;
   logic convert_strobe_i;
   logic sclk_i;
   logic cmp_above_i;
   logic track_o;
   logic hold_o;
   logic chan_two_o;
   logic power_up_o;
   logic power_ready_o;
   logic [9:0] dac_code_o;
   logic dout_o;
   logic dout_oe_o;
   logic [9:0] v1;
   logic [9:0] v2;
   logic [11:0] word;
   int bad_count;
   int n_compared;

   acs_sequencer acs_sequencer_inst (
      .clk_i(clk_i),
      .arst_n_i(arst_n_i),
      .convert_strobe_i(convert_strobe_i),
      .sclk_i(sclk_i),
      .cmp_above_i(cmp_above_i),
      .track_o(track_o),
      .hold_o(hold_o),
      .chan_two_o(chan_two_o),
      .power_up_o(power_up_o),
      .power_ready_o(power_ready_o),
      .dac_code_o(dac_code_o),
      .dout_o(dout_o),
      .dout_oe_o(dout_oe_o)
   );

   acs_host_model acs_host_model_inst (
      .clk_i(clk_i),
      .dout_i(dout_o),
      .convert_strobe_o(convert_strobe_i),
      .sclk_o(sclk_i)
   );

   initial begin
      clk_i = 1'b0;
      forever #5 clk_i = ~clk_i;
   end

   // Comparator stands in for the held analog level of the chosen input
   always @(posedge clk_i) begin
      cmp_above_i <= dac_code_o <= (chan_two_o ? v2 : v1);
   end

   task automatic check(input string name, input logic [11:0] seen,
                        input logic [11:0] exp);
      n_compared++;
      if (seen !== exp) begin
         bad_count++;
         $display("BAD %s expected %h seen %h", name, exp, seen);
      end
   endtask : check

   task automatic end_sim();
      if (bad_count == 0 && n_compared > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask : end_sim

   task automatic conv(input bit pair, input bit two);
      int n;
      logic [9:0] v;
      v = two ? v2 : v1;
      acs_host_model_inst.start(pair);
      acs_host_model_inst.wait_clk(4);
      #1;
      check("track", track_o, 1'b1);
      check("power_up", power_up_o, 1'b1);
      check("dout_low", {dout_oe_o, dout_o}, 2'b10);
      check("chan_two", chan_two_o, two);
      acs_host_model_inst.wait_clk(86);
      #1;
      if (!pair) begin
         check("power_ready_early", power_ready_o, 1'b0);
      end
      acs_host_model_inst.wait_clk(20);
      #1;
      check("power_ready", power_ready_o, 1'b1);
      acs_host_model_inst.wait_clk(40);
      acs_host_model_inst.stop();
      acs_host_model_inst.wait_clk(6);
      #1;
      check("hold_track", {hold_o, track_o}, 2'b10);
      n = 6;
      while (power_up_o !== 1'b0 && n < 400) begin
         @(negedge clk_i);
         n++;
      end
      // Result passes the fifo and its output register before it loads
      repeat (4) begin
         @(negedge clk_i);
         n++;
      end
      check("conv_in_time", n <= 370, 1'b1);
      check("shutdown", {hold_o, power_ready_o}, 2'b00);
      check("result", dac_code_o, v);
      check("msb", dout_o, v[9]);
   endtask : conv

   task automatic read_full(input logic [9:0] v);
      acs_host_model_inst.read_bits(12, word);
      check("frame", word, {v, 2'b00});
      acs_host_model_inst.wait_clk(8);
      #1;
      check("released", dout_oe_o, 1'b0);
   endtask : read_full

   task automatic t_chan_one();
      v1 = 10'h2a5;
      v2 = 10'h15a;
      conv(1'b0, 1'b0);
      read_full(v1);
   endtask : t_chan_one

   task automatic t_chan_two();
      conv(1'b1, 1'b1);
      read_full(v2);
   endtask : t_chan_two

   // Extreme codes; a fully read frame must leave channel one selectable
   task automatic t_bounds();
      logic [9:0] vals [2];
      vals[0] = 10'h000;
      vals[1] = 10'h3ff;
      foreach (vals[i]) begin
         v1 = vals[i];
         conv(1'b0, 1'b0);
         read_full(v1);
      end
   endtask : t_bounds

   // Frame left with 5 of 12 positions read forces channel two on a single rise
   task automatic t_unread();
      v1 = 10'h1c3;
      v2 = 10'h0e6;
      conv(1'b0, 1'b0);
      acs_host_model_inst.read_bits(5, word);
      check("part_frame", word[4:0], v1[9:5]);
      #1;
      check("still_driven", dout_oe_o, 1'b1);
      conv(1'b0, 1'b1);
      read_full(v2);
   endtask : t_unread

   // Reset in mid tracking must leave the block idle and usable again
   task automatic t_reset();
      v1 = 10'h0f0;
      acs_host_model_inst.start(1'b0);
      acs_host_model_inst.wait_clk(20);
      arst_n_i <= 1'b0;
      acs_host_model_inst.stop();
      acs_host_model_inst.wait_clk(8);
      #1;
      check("reset_idle", {track_o, hold_o, power_up_o, power_ready_o,
            chan_two_o, dout_oe_o, dout_o}, 7'h00);
      check("reset_code", dac_code_o, 10'h000);
      @(posedge clk_i);
      arst_n_i <= 1'b1;
      conv(1'b0, 1'b0);
      read_full(v1);
   endtask : t_reset

   initial begin
      bad_count = 0;
      n_compared = 0;
      arst_n_i = 1'b0;
      v1 = 10'h000;
      v2 = 10'h000;
      repeat (8) @(posedge clk_i);
      arst_n_i <= 1'b1;
      repeat (4) @(posedge clk_i);
      t_chan_one();
      t_chan_two();
      t_bounds();
      t_unread();
      t_reset();
      end_sim();
   end

   // Seven conversions with frames take under 6000 cycles
   initial begin
      repeat (20000) @(posedge clk_i);
      bad_count++;
      end_sim();
   end
endmodule : adc_conversion_sequencer_tb_top
